// File: rtl/dio_in_select.sv
// Input selector: picks one input level by its command index.
// Assumes the stepper flag is a steady configuration level.
module dio_in_select
(
  input  wire logic [dio_pkg::IDX_BITS-1:0] idx_in,
  input  wire logic [dio_pkg::IN_BITS-1:0]  inputs_in,
  input  wire logic                         aux_a_in,
  input  wire logic                         aux_b_in,
  input  wire logic                         stepper_mode_in,
  output logic                              level_out,
  output logic                              valid_out
);
  logic [dio_pkg::IDX_BITS-1:0] off;

  always_comb
  begin
    off = idx_in - dio_pkg::IN_FIRST;
    level_out = 1'b0;
    valid_out = 1'b0;
    if (idx_in >= dio_pkg::IN_FIRST && idx_in <= dio_pkg::IN_LAST)
    begin
      level_out = inputs_in[off[2:0]];
      valid_out = 1'b1;
    end
    else if (idx_in == dio_pkg::AUX_A_IDX && !stepper_mode_in)
    begin
      level_out = aux_a_in;
      valid_out = 1'b1;
    end
    else if (idx_in == dio_pkg::AUX_B_IDX && !stepper_mode_in)
    begin
      level_out = aux_b_in;
      valid_out = 1'b1;
    end
  end
endmodule

// File: rtl/dio_out_port.sv
// Output latch for the four general outputs.
// Assumes one-cycle command strobes from the interpreter.
module dio_out_port
(
  input  wire logic                          clock_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          bit_we_in,
  input  wire logic [dio_pkg::OUT_BITS-1:0]  bit_sel_in,
  input  wire logic                          bit_val_in,
  input  wire logic                          word_we_in,
  input  wire logic [dio_pkg::WORD_BITS-1:0] word_in,
  output logic      [dio_pkg::OUT_BITS-1:0]  out_lines_out
);
  logic [dio_pkg::OUT_BITS-1:0] out_r;
  logic [dio_pkg::OUT_BITS-1:0] out_nxt;

  always_comb
  begin
    out_nxt = out_r;
    if (word_we_in)
    begin
      out_nxt = word_in[dio_pkg::OUT_BITS-1:0];
    end
    else if (bit_we_in)
    begin
      for (int i = 0; i < dio_pkg::OUT_BITS; i++)
      begin
        if (bit_sel_in[i])
        begin
          out_nxt[i] = bit_val_in;
        end
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      out_r <= dio_pkg::OUT_RESET;
    end
    else
    begin
      out_r <= out_nxt;
    end
  end

  assign out_lines_out = out_r;
endmodule

// File: rtl/motion_ctrl_digital_io.sv
// Digital I/O block of a motion controller: output port and input access.
// Assumes commands arrive as one-cycle strobes from the interpreter.
// Functional notes
// - Four independent output lines
// - Set or clear one named output
// - Conditional output follows operand non-zero
// - Word write, bit 0 is output 1
// - Word 0 clears all, 15 sets all
// - Level query for inputs 1 to 8
// - Tell-inputs reports all inputs
// - Hold until input high, negative low
// - Aux encoder A,B read as 81,82
// - Aux inputs unavailable in stepper mode
module motion_ctrl_digital_io
(
  input  wire logic                          clock_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          cmd_valid_in,
  input  dio_pkg::cmd_e                      cmd_in,
  input  wire logic [dio_pkg::IDX_BITS-1:0]  cmd_idx_in,
  input  wire logic                          cmd_idx_neg_in,
  input  wire logic [dio_pkg::WORD_BITS-1:0] cmd_value_in,
  input  wire logic [dio_pkg::IN_BITS-1:0]   inputs_in,
  input  wire logic                          aux_a_in,
  input  wire logic                          aux_b_in,
  input  wire logic                          stepper_mode_in,
  output logic                               cmd_ready_out,
  output logic                               resp_valid_out,
  output logic                               resp_level_out,
  output logic                               resp_error_out,
  output logic [dio_pkg::TELL_BITS-1:0]      tell_value_out,
  output logic                               hold_busy_out,
  output logic [dio_pkg::OUT_BITS-1:0]       out_lines_out
);
  dio_pkg::wait_e               wait_r;
  dio_pkg::wait_e               wait_nxt;
  logic [dio_pkg::IDX_BITS-1:0] hidx_r;
  logic [dio_pkg::IDX_BITS-1:0] hidx_nxt;
  logic                         hneg_r;
  logic                         hneg_nxt;
  logic                         rv_r;
  logic                         rv_nxt;
  logic                         rl_r;
  logic                         rl_nxt;
  logic                         re_r;
  logic                         re_nxt;
  logic [dio_pkg::TELL_BITS-1:0] tv_r;
  logic [dio_pkg::TELL_BITS-1:0] tv_nxt;
  logic [dio_pkg::IDX_BITS-1:0] sel_idx;
  logic                         sel_level;
  logic                         sel_valid;
  logic                         take;
  logic                         out_idx_ok;
  logic [dio_pkg::OUT_BITS-1:0] bit_sel;
  logic                         bit_we;
  logic                         bit_val;
  logic                         word_we;
  logic [dio_pkg::IDX_BITS-1:0] out_off;

  assign cmd_ready_out = (wait_r == dio_pkg::WAIT_IDLE);
  assign take = cmd_valid_in && cmd_ready_out;
  assign sel_idx = (wait_r == dio_pkg::WAIT_BUSY) ? hidx_r : cmd_idx_in;
  assign out_off = cmd_idx_in - dio_pkg::OUT_FIRST;
  assign out_idx_ok = cmd_idx_in >= dio_pkg::OUT_FIRST &&
                      cmd_idx_in <= dio_pkg::OUT_LAST;

  dio_in_select u_sel
  (
    .idx_in          (sel_idx),
    .inputs_in       (inputs_in),
    .aux_a_in        (aux_a_in),
    .aux_b_in        (aux_b_in),
    .stepper_mode_in (stepper_mode_in),
    .level_out       (sel_level),
    .valid_out       (sel_valid)
  );

  always_comb
  begin
    bit_we  = 1'b0;
    bit_val = 1'b0;
    word_we = 1'b0;
    bit_sel = '0;
    for (int i = 0; i < dio_pkg::OUT_BITS; i++)
    begin
      bit_sel[i] = (out_off[1:0] == i[1:0]);
    end
    if (take && out_idx_ok)
    begin
      case (cmd_in)
        dio_pkg::CMD_SET_BIT:
        begin
          bit_we  = 1'b1;
          bit_val = 1'b1;
        end
        dio_pkg::CMD_CLEAR_BIT:
        begin
          bit_we  = 1'b1;
          bit_val = 1'b0;
        end
        dio_pkg::CMD_COND_OUT:
        begin
          bit_we  = 1'b1;
          bit_val = |cmd_value_in;
        end
        default:
        begin
          bit_we = 1'b0;
        end
      endcase
    end
    if (take && cmd_in == dio_pkg::CMD_PORT_WRITE)
    begin
      word_we = 1'b1;
    end
  end

  dio_out_port u_out
  (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .bit_we_in     (bit_we),
    .bit_sel_in    (bit_sel),
    .bit_val_in    (bit_val),
    .word_we_in    (word_we),
    .word_in       (cmd_value_in),
    .out_lines_out (out_lines_out)
  );

  always_comb
  begin
    wait_nxt = wait_r;
    hidx_nxt = hidx_r;
    hneg_nxt = hneg_r;
    rv_nxt   = 1'b0;
    rl_nxt   = rl_r;
    re_nxt   = 1'b0;
    tv_nxt   = tv_r;
    case (wait_r)
      dio_pkg::WAIT_IDLE:
      begin
        if (take)
        begin
          case (cmd_in)
            dio_pkg::CMD_QUERY_IN:
            begin
              rv_nxt = 1'b1;
              rl_nxt = sel_level;
              re_nxt = !sel_valid;
            end
            dio_pkg::CMD_TELL_IN:
            begin
              rv_nxt = 1'b1;
              re_nxt = 1'b0;
              tv_nxt = {aux_b_in && !stepper_mode_in,
                        aux_a_in && !stepper_mode_in,
                        inputs_in};
            end
            dio_pkg::CMD_HOLD_IN:
            begin
              if (!sel_valid)
              begin
                rv_nxt = 1'b1;
                re_nxt = 1'b1;
              end
              else if (sel_level != cmd_idx_neg_in)
              begin
                rv_nxt = 1'b1;
              end
              else
              begin
                wait_nxt = dio_pkg::WAIT_BUSY;
                hidx_nxt = cmd_idx_in;
                hneg_nxt = cmd_idx_neg_in;
              end
            end
            default:
            begin
              rv_nxt = (cmd_in != dio_pkg::CMD_NONE);
              re_nxt = (cmd_in != dio_pkg::CMD_PORT_WRITE) &&
                       (cmd_in != dio_pkg::CMD_NONE) && !out_idx_ok;
            end
          endcase
        end
      end
      dio_pkg::WAIT_BUSY:
      begin
        if (!sel_valid)
        begin
          wait_nxt = dio_pkg::WAIT_IDLE;
          rv_nxt   = 1'b1;
          re_nxt   = 1'b1;
        end
        else if (sel_level != hneg_r)
        begin
          wait_nxt = dio_pkg::WAIT_IDLE;
          rv_nxt   = 1'b1;
        end
      end
      default:
      begin
        wait_nxt = dio_pkg::WAIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      wait_r <= dio_pkg::WAIT_IDLE;
      hidx_r <= '0;
      hneg_r <= 1'b0;
      rv_r   <= 1'b0;
      rl_r   <= 1'b0;
      re_r   <= 1'b0;
      tv_r   <= '0;
    end
    else
    begin
      wait_r <= wait_nxt;
      hidx_r <= hidx_nxt;
      hneg_r <= hneg_nxt;
      rv_r   <= rv_nxt;
      rl_r   <= rl_nxt;
      re_r   <= re_nxt;
      tv_r   <= tv_nxt;
    end
  end

  assign resp_valid_out = rv_r;
  assign resp_level_out = rl_r;
  assign resp_error_out = re_r;
  assign tell_value_out = tv_r;
  assign hold_busy_out  = (wait_r == dio_pkg::WAIT_BUSY);

  property p_set_bit;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && cmd_in == dio_pkg::CMD_SET_BIT && cmd_idx_in == dio_pkg::OUT_FIRST
    |=> out_lines_out[0];
  endproperty
  a_set_bit: assert property (p_set_bit)
    else $error("Set bit did not raise output");

  property p_clr_bit;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && cmd_in == dio_pkg::CMD_CLEAR_BIT && out_idx_ok
    |=> out_lines_out == ($past(out_lines_out) & ~$past(bit_sel));
  endproperty
  a_clr_bit: assert property (p_clr_bit)
    else $error("Clear bit wrong");

  property p_cond;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && cmd_in == dio_pkg::CMD_COND_OUT && out_idx_ok
    |=> ((out_lines_out & $past(bit_sel)) != 4'h0) ==
        ($past(cmd_value_in) != 16'h0000);
  endproperty
  a_cond: assert property (p_cond)
    else $error("Conditional output wrong");

  property p_word;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && cmd_in == dio_pkg::CMD_PORT_WRITE
    |=> out_lines_out == $past(cmd_value_in[dio_pkg::OUT_BITS-1:0]);
  endproperty
  a_word: assert property (p_word)
    else $error("Port write wrong");

  property p_word15;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && cmd_in == dio_pkg::CMD_PORT_WRITE && cmd_value_in == 16'h000F
    |=> out_lines_out == 4'hF;
  endproperty
  a_word15: assert property (p_word15)
    else $error("Write 15 did not set all");

  property p_query;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && cmd_in == dio_pkg::CMD_QUERY_IN && cmd_idx_in == 8'h0003
    |=> resp_valid_out && resp_level_out == $past(inputs_in[2]);
  endproperty
  a_query: assert property (p_query)
    else $error("Query level wrong");

  property p_tell;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && cmd_in == dio_pkg::CMD_TELL_IN
    |=> tell_value_out[7:0] == $past(inputs_in);
  endproperty
  a_tell: assert property (p_tell)
    else $error("Tell inputs wrong");

  property p_hold;
    @(posedge clock_in) disable iff (!rst_n_in)
    hold_busy_out && sel_valid && sel_level == hneg_r
    |=> hold_busy_out && !resp_valid_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Hold ended early");

  property p_step;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && cmd_in == dio_pkg::CMD_QUERY_IN && stepper_mode_in &&
    cmd_idx_in == dio_pkg::AUX_A_IDX |=> resp_error_out;
  endproperty
  a_step: assert property (p_step)
    else $error("Aux input readable in stepper mode");

  property p_hold_out;
    @(posedge clock_in) disable iff (!rst_n_in)
    rst_n_in && !bit_we && !word_we |=> $stable(out_lines_out);
  endproperty
  a_hold_out: assert property (p_hold_out)
    else $error("Output changed without command");

  c_word: cover property (@(posedge clock_in) word_we);
  c_wait: cover property (@(posedge clock_in) $fell(hold_busy_out));
  c_aux: cover property (@(posedge clock_in)
    take && cmd_in == dio_pkg::CMD_QUERY_IN &&
    cmd_idx_in == dio_pkg::AUX_B_IDX && sel_valid);
endmodule

// File: shared/dio_pkg.sv
// Package for the motion controller digital I/O block.
// Assumes a single 20 MHz clock and synchronous active-low reset.
package dio_pkg;
  localparam int OUT_BITS  = 4;
  localparam int IN_BITS   = 8;
  localparam int WORD_BITS = 16;
  localparam int IDX_BITS  = 8;
  localparam logic [OUT_BITS-1:0] OUT_RESET = 4'h0;
  localparam logic [IDX_BITS-1:0] IN_FIRST = 8'h01;
  localparam logic [IDX_BITS-1:0] IN_LAST  = 8'h08;
  localparam logic [IDX_BITS-1:0] AUX_A_IDX = 8'h51;
  localparam logic [IDX_BITS-1:0] AUX_B_IDX = 8'h52;
  localparam logic [IDX_BITS-1:0] OUT_FIRST = 8'h01;
  localparam logic [IDX_BITS-1:0] OUT_LAST  = 8'h04;
  localparam int TELL_BITS = 10;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_SET_BIT,
    CMD_CLEAR_BIT,
    CMD_COND_OUT,
    CMD_PORT_WRITE,
    CMD_QUERY_IN,
    CMD_TELL_IN,
    CMD_HOLD_IN
  } cmd_e;

  typedef enum logic {
    WAIT_IDLE,
    WAIT_BUSY
  } wait_e;
endpackage

// File: tb/motion_ctrl_digital_io_test.sv
// Self-checking bench for the digital I/O block.
// Assumes a 20 MHz clock and the sensor model on the input pins.
module motion_ctrl_digital_io_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clock_in = 1'b0;
  logic          rst_n = 1'b0;
  logic          cmd_valid = 1'b0;
  dio_pkg::cmd_e cmd_v = dio_pkg::CMD_NONE;
  logic [7:0]    idx = 8'h00;
  logic          neg = 1'b0;
  logic [15:0]   val = 16'h0000;
  logic          stepper = 1'b0;
  logic          load = 1'b0;
  logic [9:0]    lvl = 10'h000;
  logic [7:0]    dly = 8'h00;
  logic          ready, resp_valid, resp_level, resp_error, busy;
  logic          aux_a, aux_b, saw_busy;
  logic [9:0]    tell;
  logic [3:0]    outs, exp_o;
  logic [7:0]    ins;
  int            n_mismatch = 0;
  int            n_tests = 0;
  int            cycles = 0;
  int            n_wait;

  always #25 clock_in = ~clock_in;

  motion_ctrl_digital_io u_dut
  (
    .clock_in        (clock_in),
    .rst_n_in        (rst_n),
    .cmd_valid_in    (cmd_valid),
    .cmd_in          (cmd_v),
    .cmd_idx_in      (idx),
    .cmd_idx_neg_in  (neg),
    .cmd_value_in    (val),
    .inputs_in       (ins),
    .aux_a_in        (aux_a),
    .aux_b_in        (aux_b),
    .stepper_mode_in (stepper),
    .cmd_ready_out   (ready),
    .resp_valid_out  (resp_valid),
    .resp_level_out  (resp_level),
    .resp_error_out  (resp_error),
    .tell_value_out  (tell),
    .hold_busy_out   (busy),
    .out_lines_out   (outs)
  );

  sensor_bank u_sense
  (
    .clock_in   (clock_in),
    .load_in    (load),
    .level_in   (lvl),
    .delay_in   (dly),
    .inputs_out (ins),
    .aux_a_out  (aux_a),
    .aux_b_out  (aux_b)
  );

  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Loads new levels; with no delay, waits until they are on the pins
  task automatic sense(input logic [9:0] l, input logic [7:0] d);
    @(posedge clock_in);
    load <= 1'b1;
    lvl <= l;
    dly <= d;
    @(posedge clock_in);
    load <= 1'b0;
    if (d == 8'h00)
      repeat (2) @(posedge clock_in);
  endtask

  task automatic do_cmd(input dio_pkg::cmd_e c, input logic [7:0] i,
                        input logic n, input logic [15:0] v);
    @(posedge clock_in);
    cmd_valid <= 1'b1;
    cmd_v <= c;
    idx <= i;
    neg <= n;
    val <= v;
    @(posedge clock_in);
    cmd_valid <= 1'b0;
    saw_busy = 1'b0;
    n_wait = 0;
    // The response pulse stands for one cycle, from the taking edge or from the edge that ends a hold
    #1;
    while (resp_valid !== 1'b1 && n_wait < 60)
    begin
      if (busy === 1'b1 && ready === 1'b0)
        saw_busy = 1'b1;
      @(posedge clock_in);
      #1;
      n_wait++;
    end
    chk(resp_valid, 1, "no response");
  endtask

  task automatic t_bits();
    exp_o = 4'h0;
    for (int i = 1; i <= 4; i++)
    begin
      do_cmd(dio_pkg::CMD_SET_BIT, 8'(i), 1'b0, 16'h0000);
      exp_o[i-1] = 1'b1;
      chk(outs, exp_o, "set bit");
    end
    do_cmd(dio_pkg::CMD_SET_BIT, 8'h05, 1'b0, 16'h0000);
    chk(resp_error, 1, "bad output number");
    for (int i = 4; i >= 1; i -= 3)
    begin
      do_cmd(dio_pkg::CMD_CLEAR_BIT, 8'(i), 1'b0, 16'h0000);
      exp_o[i-1] = 1'b0;
      chk(outs, exp_o, "clear bit");
    end
  endtask

  task automatic t_cond();
    do_cmd(dio_pkg::CMD_COND_OUT, 8'h01, 1'b0, 16'h8000);
    chk(outs, 4'h7, "cond high word");
    do_cmd(dio_pkg::CMD_COND_OUT, 8'h03, 1'b0, 16'h0000);
    chk(outs, 4'h3, "cond zero");
  endtask

  task automatic t_word();
    logic [15:0] w[5] = '{16'h0006, 16'h0000, 16'h000F, 16'hFFF0, 16'h0009};
    for (int k = 0; k < 5; k++)
    begin
      do_cmd(dio_pkg::CMD_PORT_WRITE, 8'h00, 1'b0, w[k]);
      chk(outs, w[k][3:0], "word write");
    end
    do_cmd(dio_pkg::CMD_SET_BIT, 8'h02, 1'b0, 16'h0000);
    chk(outs, 4'hB, "outputs hold");
  endtask

  task automatic t_reset();
    @(posedge clock_in);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n <= 1'b1;
    @(posedge clock_in);
    #1;
    chk(outs, 4'h0, "reset clears outputs");
    chk({ready, busy}, 2'b10, "ready after reset");
  endtask

  task automatic t_inputs();
    sense(10'h2A5, 8'h00);
    for (int i = 1; i <= 8; i++)
    begin
      do_cmd(dio_pkg::CMD_QUERY_IN, 8'(i), 1'b0, 16'h0000);
      chk(resp_level, lvl[i-1], "input level");
      chk(resp_error, 0, "input error");
    end
    do_cmd(dio_pkg::CMD_QUERY_IN, 8'h09, 1'b0, 16'h0000);
    chk(resp_error, 1, "input nine");
    do_cmd(dio_pkg::CMD_TELL_IN, 8'h00, 1'b0, 16'h0000);
    chk(tell, 10'h2A5, "tell inputs");
    do_cmd(dio_pkg::CMD_QUERY_IN, 8'h51, 1'b0, 16'h0000);
    chk(resp_level, 0, "aux a");
    chk(resp_error, 0, "aux a valid");
    do_cmd(dio_pkg::CMD_QUERY_IN, 8'h52, 1'b0, 16'h0000);
    chk(resp_level, 1, "aux b");
    @(posedge clock_in);
    stepper <= 1'b1;
    do_cmd(dio_pkg::CMD_QUERY_IN, 8'h52, 1'b0, 16'h0000);
    chk(resp_error, 1, "aux in stepper");
    do_cmd(dio_pkg::CMD_QUERY_IN, 8'h51, 1'b0, 16'h0000);
    chk(resp_error, 1, "aux a in stepper");
    do_cmd(dio_pkg::CMD_TELL_IN, 8'h00, 1'b0, 16'h0000);
    chk(tell, 10'h0A5, "tell in stepper");
    @(posedge clock_in);
    stepper <= 1'b0;
  endtask

  task automatic t_hold();
    sense(10'h020, 8'h00);
    sense(10'h060, 8'h06);
    do_cmd(dio_pkg::CMD_HOLD_IN, 8'h07, 1'b0, 16'h0000);
    chk(saw_busy, 1, "hold high stalls");
    chk(ins[6], 1, "hold high level");
    sense(10'h040, 8'h05);
    do_cmd(dio_pkg::CMD_HOLD_IN, 8'h06, 1'b1, 16'h0000);
    chk(saw_busy, 1, "hold low stalls");
    chk(ins[5], 0, "hold low level");
    do_cmd(dio_pkg::CMD_HOLD_IN, 8'h07, 1'b0, 16'h0000);
    chk(16'(n_wait <= 2), 1, "hold already met");
  endtask

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (2) @(posedge clock_in);
    rst_n <= 1'b1;
    @(posedge clock_in);
    #1;
    chk(outs, 4'h0, "reset outputs");
    chk({ready, busy}, 2'b10, "reset ready");
    t_bits();
    t_cond();
    t_word();
    t_reset();
    t_inputs();
    t_hold();
    end_of_test();
  end
endmodule

// File: tb/sensor_bank.sv
// Model of the switches and sensors wired to the general inputs.
// Assumes the bench loads a new level set and a delay in cycles.
module sensor_bank
(
  input  wire logic       clock_in,
  input  wire logic       load_in,
  input  wire logic [9:0] level_in,
  input  wire logic [7:0] delay_in,
  output logic      [7:0] inputs_out,
  output logic            aux_a_out,
  output logic            aux_b_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] pend_r = 10'h000;
  logic [7:0] cnt_r = 8'h00;
  logic       busy_r = 1'b0;
  initial {aux_b_out, aux_a_out, inputs_out} = 10'h000;
  // Levels change after the delay, so waits can be met late
  always @(posedge clock_in)
  begin
    if (load_in)
    begin
      pend_r <= level_in;
      cnt_r <= delay_in;
      busy_r <= 1'b1;
    end
    else if (busy_r && cnt_r == 8'h00)
    begin
      {aux_b_out, aux_a_out, inputs_out} <= pend_r;
      busy_r <= 1'b0;
    end
    else if (busy_r)
      cnt_r <= cnt_r - 8'h01;
  end
endmodule
